/* dv/tb.sv */
// Self-checking bench for the sync/profile register bank
`timescale 1ns/100ps
module tb import usp_pkg::*;;
    logic core_clk, reset, reg_wr, reg_rd, reg_rvalid, cfg_ram_enable, segment_toggle_pin;
    logic sync_in_pulse, sync_rx_enable, sync_gen_enable, sync_gen_falling, spectral_invert;
    logic inv_cci_bypass, ram_wr;
    logic [4:0] reg_addr, sync_gen_delay, sync_rx_delay;
    logic [63:0] reg_wdata, reg_rdata, rv, p;
    logic [1:0] cfg_mode;
    logic [2:0] profile_sel;
    logic [3:0] sync_valid_delay;
    logic [5:0] clk_gen_state, cci_rate;
    logic [31:0] synth_ftw, ram_data;
    logic [15:0] synth_pow, gpio_in, gpio_out, gpio_oe, ext_level;
    logic [13:0] synth_asf;
    logic [7:0] out_scale;
    logic [9:0] seg_start, seg_end, ram_addr;
    int n_fail, n_compared;
    usp_regs u_usp_regs (.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .cfg_mode(cfg_mode), .cfg_ram_enable(cfg_ram_enable),
        .segment_toggle_pin(segment_toggle_pin), .profile_sel(profile_sel),
        .sync_in_pulse(sync_in_pulse), .sync_valid_delay(sync_valid_delay),
        .sync_rx_enable(sync_rx_enable), .sync_gen_enable(sync_gen_enable),
        .sync_gen_falling(sync_gen_falling), .sync_gen_delay(sync_gen_delay),
        .sync_rx_delay(sync_rx_delay), .clk_gen_state(clk_gen_state), .synth_ftw(synth_ftw),
        .synth_pow(synth_pow), .synth_asf(synth_asf), .out_scale(out_scale),
        .cci_rate(cci_rate), .spectral_invert(spectral_invert),
        .inv_cci_bypass(inv_cci_bypass), .seg_start(seg_start), .seg_end(seg_end),
        .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_data(ram_data), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe));
    usp_gpio_pins u_usp_gpio_pins (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .ext_level(ext_level), .gpio_in(gpio_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [63:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr
    // Answer is a one-cycle pulse, so it is looked at in that very cycle
    task automatic rd(input logic [4:0] a);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk("rvalid", 64'h1, reg_rvalid);
        rv = reg_rdata;
    endtask : rd
    function automatic logic [63:0] pv(input int i);
        return 64'hFEDC_BA98_7654_3210 + 64'h1111_1111_1111_1111 * 64'(i);
    endfunction : pv
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_sync;
        rd(USP_ADDR_SYNC);
        chk("sync reset", USP_SYNC_RST, rv);
        p = 64'h5A5A_A5A5;
        wr(USP_ADDR_SYNC, p);
        chk("sync fields", {p[31:25], p[15:11], p[7:3]}, {sync_valid_delay, sync_rx_enable,
            sync_gen_enable, sync_gen_falling, sync_gen_delay, sync_rx_delay});
        @(negedge core_clk);
        sync_in_pulse = 1'b1;
        @(negedge core_clk);
        sync_in_pulse = 1'b0;
        chk("preset", p[23:18], clk_gen_state);
        wr(USP_ADDR_SYNC, 64'hFFFF_FFFF_FFFF_FFFF);
        rd(USP_ADDR_SYNC);
        chk("sync reserved", USP_SYNC_MASK, rv);
        $display("test sync done");
    endtask : t_sync
    task automatic t_prof;
        logic [1:0] md;
        for (int i = 0; i < USP_NPROF; i++) wr(USP_ADDR_PROF0 + 5'(i), pv(i));
        for (int i = 0; i < USP_NPROF; i++) begin
            rd(USP_ADDR_PROF0 + 5'(i));
            chk("profile", pv(i), rv);
        end
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < USP_NPROF; i++) begin
                md = 2'(m);
                @(negedge core_clk);
                cfg_mode = md;
                profile_sel = 3'(i);
                @(negedge core_clk);
                p = pv(i);
                chk("ftw pow", md == USP_MODE_INTERP ? 48'h0 : p[47:0],
                    {synth_pow, synth_ftw});
                chk("asf", md == USP_MODE_TONE ? p[61:48] : 14'h0, synth_asf);
                chk("rate byp", m < 2 ? {p[63:58], p[56]} : 7'h0,
                    {cci_rate, inv_cci_bypass});
                chk("invert", md == USP_MODE_QUC ? p[57] : 1'b0, spectral_invert);
                chk("oscale", m < 2 ? p[55:48] : 8'h0, out_scale);
            end
        end
        $display("test profiles done");
    endtask : t_prof
    task automatic t_ram;
        wr(USP_ADDR_SEG0, 64'h0100_00C0);
        @(negedge core_clk);
        segment_toggle_pin = 1'b1;
        @(negedge core_clk);
        chk("seg unarmed", 64'h0, seg_start);
        segment_toggle_pin = 1'b0;
        cfg_ram_enable = 1'b1;
        @(negedge core_clk);
        segment_toggle_pin = 1'b1;
        @(negedge core_clk);
        chk("seg bounds", {10'h004, 10'h003}, {seg_end, seg_start});
        // Third word runs past the end address and must wrap
        for (int k = 0; k < 3; k++) begin
            wr(USP_ADDR_RAM, 64'hC0DE_0000 + 64'(k));
            chk("ram word", {1'b1, k == 1 ? 10'h004 : 10'h003, 32'hC0DE_0000 + 32'(k)},
                {ram_wr, ram_addr, ram_data});
        end
        $display("test ram done");
    endtask : t_ram
    task automatic t_gpio;
        ext_level = 16'h1234;
        wr(USP_ADDR_GPIO_CFG, 64'hFF00);
        wr(USP_ADDR_GPIO_DAT, 64'hABCD);
        chk("gpio pins", 32'hFF00_ABCD, {gpio_oe, gpio_out});
        rd(USP_ADDR_GPIO_DAT);
        chk("gpio read", 64'hAB34, rv);
        wr(5'h1F, 64'hFFFF);
        rd(5'h1F);
        chk("unmapped", 64'h0, rv);
        $display("test gpio done");
    endtask : t_gpio
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        {reset, reg_wr, reg_rd, cfg_ram_enable, segment_toggle_pin, sync_in_pulse} = 6'h20;
        {reg_addr, reg_wdata, cfg_mode, profile_sel, ext_level} = '0;
        n_fail = 0;
        n_compared = 0;
        repeat (5) @(negedge core_clk);
        reset = 1'b0;
        t_sync;
        t_prof;
        t_ram;
        t_gpio;
        end_sim;
    end
endmodule : tb

/* dv/usp_gpio_pins.sv */
// Far-side model of the GPIO pads
`timescale 1ns/100ps
module usp_gpio_pins (
    input wire logic [15:0] gpio_out,
    input wire logic [15:0] gpio_oe,
    input wire logic [15:0] ext_level,
    output logic [15:0] gpio_in
);
    // Driven pads read back the bank's value; others show the outside level
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
endmodule : usp_gpio_pins

/* dv/usp_regs_chk.sv */
// Port-level checker for the sync/profile register bank
`timescale 1ns/100ps
module usp_regs_chk
    import usp_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [USP_AW-1:0] reg_addr,
    input wire logic [USP_DW-1:0] reg_wdata,
    input wire logic reg_rvalid,
    input wire logic [1:0] cfg_mode,
    input wire logic sync_in_pulse,
    input wire logic sync_rx_enable,
    input wire logic [3:0] sync_valid_delay,
    input wire logic [5:0] clk_gen_state,
    input wire logic [31:0] synth_ftw,
    input wire logic [7:0] out_scale,
    input wire logic ram_wr,
    input wire logic [31:0] ram_data,
    input wire logic [15:0] gpio_oe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    chk_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    chk_skew_field: assert property (
        reg_wr && reg_addr == USP_ADDR_SYNC |=> sync_valid_delay == $past(reg_wdata[31:28]))
        else $error("skew field wrong");
    chk_gen_count: assert property (
        !(sync_in_pulse && sync_rx_enable) |=> clk_gen_state == $past(clk_gen_state) + 6'h01)
        else $error("generator state jumped");
    chk_ram_pulse: assert property (
        reg_wr && reg_addr == USP_ADDR_RAM |=> ram_wr && ram_data == $past(reg_wdata[31:0]))
        else $error("ram word not passed");
    chk_ram_quiet: assert property (!(reg_wr && reg_addr == USP_ADDR_RAM) |=> !ram_wr)
        else $error("stray ram write");
    chk_gpio_dir: assert property (
        reg_wr && reg_addr == USP_ADDR_GPIO_CFG |=> gpio_oe == $past(reg_wdata[15:0]))
        else $error("gpio direction wrong");
    chk_interp_ftw: assert property (cfg_mode == USP_MODE_INTERP |=> synth_ftw == 32'h0)
        else $error("interp mode kept frequency");
    chk_tone_scale: assert property (cfg_mode == USP_MODE_TONE |=> out_scale == 8'h00)
        else $error("tone mode kept output scale");
endmodule : usp_regs_chk
////////////////////////////////////////////////////////////////////////////////
bind usp_regs usp_regs_chk u_chk (.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
    .cfg_mode(cfg_mode), .sync_in_pulse(sync_in_pulse), .sync_rx_enable(sync_rx_enable),
    .sync_valid_delay(sync_valid_delay), .clk_gen_state(clk_gen_state),
    .synth_ftw(synth_ftw), .out_scale(out_scale), .ram_wr(ram_wr), .ram_data(ram_data),
    .gpio_oe(gpio_oe));

/* rtl/usp_pkg.sv */
// Package: addresses, field positions, masks and reset values of the sync/profile bank
package usp_pkg;
    localparam int USP_AW = 5;
    localparam int USP_DW = 64;
    localparam int USP_NPROF = 8;
    // Register addresses on the serial port
    localparam logic [4:0] USP_ADDR_SEG0 = 5'h05;
    localparam logic [4:0] USP_ADDR_SEG1 = 5'h06;
    localparam logic [4:0] USP_ADDR_SYNC = 5'h0A;
    localparam logic [4:0] USP_ADDR_PROF0 = 5'h0E;
    localparam logic [4:0] USP_ADDR_PROF7 = 5'h15;
    localparam logic [4:0] USP_ADDR_RAM = 5'h16;
    localparam logic [4:0] USP_ADDR_GPIO_CFG = 5'h18;
    localparam logic [4:0] USP_ADDR_GPIO_DAT = 5'h19;
    // Writable bits; all others read zero
    localparam logic [31:0] USP_SYNC_MASK = 32'hFEFC_F8F8;
    localparam logic [47:0] USP_SEG_MASK = 48'hFFFF_FFC0_FFC7;
    // Reset values
    localparam logic [31:0] USP_SYNC_RST = 32'h0000_0000;
    localparam logic [63:0] USP_PROF_RST = 64'h0000_0000_0000_0000;
    localparam logic [47:0] USP_SEG_RST = 48'h0000_0000_0000;
    localparam logic [15:0] USP_GPIO_RST = 16'h0000;
    // Sync register fields
    localparam int USP_SYNC_VAL_DLY_LSB = 28;
    localparam int USP_SYNC_RX_EN_BIT = 27;
    localparam int USP_SYNC_GEN_EN_BIT = 26;
    localparam int USP_SYNC_GEN_POL_BIT = 25;
    localparam int USP_SYNC_PRESET_LSB = 18;
    localparam int USP_SYNC_GEN_DLY_LSB = 11;
    localparam int USP_SYNC_RX_DLY_LSB = 3;
    // Profile fields
    localparam int USP_PF_FTW_LSB = 0;
    localparam int USP_PF_POW_LSB = 32;
    localparam int USP_PF_ASF_LSB = 48;
    localparam int USP_PF_OSF_LSB = 48;
    localparam int USP_PF_BYP_BIT = 56;
    localparam int USP_PF_INV_BIT = 57;
    localparam int USP_PF_CCI_LSB = 58;
    // Segment fields
    localparam int USP_SEG_START_LSB = 6;
    localparam int USP_SEG_END_LSB = 22;
    // Operating mode codes of the primary config register mode field
    typedef enum logic [1:0] {
        USP_MODE_QUC = 2'b00,
        USP_MODE_INTERP = 2'b01,
        USP_MODE_TONE = 2'b10,
        USP_MODE_RSVD = 2'b11
    } usp_mode_t;
endpackage : usp_pkg

/* rtl/usp_regs.sv */
// Sync control, profile, waveform RAM access and GPIO register bank
`timescale 1ns/100ps
module usp_regs
    import usp_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [USP_AW-1:0] reg_addr,
    input wire logic [USP_DW-1:0] reg_wdata,
    output logic [USP_DW-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [1:0] cfg_mode,
    input wire logic cfg_ram_enable,
    input wire logic segment_toggle_pin,
    input wire logic [2:0] profile_sel,
    input wire logic sync_in_pulse,
    output logic [3:0] sync_valid_delay,
    output logic sync_rx_enable,
    output logic sync_gen_enable,
    output logic sync_gen_falling,
    output logic [4:0] sync_gen_delay,
    output logic [4:0] sync_rx_delay,
    output logic [5:0] clk_gen_state,
    output logic [31:0] synth_ftw,
    output logic [15:0] synth_pow,
    output logic [13:0] synth_asf,
    output logic [7:0] out_scale,
    output logic [5:0] cci_rate,
    output logic spectral_invert,
    output logic inv_cci_bypass,
    output logic [9:0] seg_start,
    output logic [9:0] seg_end,
    output logic ram_wr,
    output logic [9:0] ram_addr,
    output logic [31:0] ram_data,
    input wire logic [15:0] gpio_in,
    output logic [15:0] gpio_out,
    output logic [15:0] gpio_oe
);

    typedef struct packed {
        logic [31:0] sync;
        logic [USP_NPROF-1:0][63:0] prof;
        logic [47:0] seg0;
        logic [47:0] seg1;
        logic [31:0] ram_word;
        logic [15:0] gpio_cfg;
        logic [15:0] gpio_dat;
        logic [63:0] rdata;
        logic rvalid;
        logic toggle_q;
        logic [9:0] act_start;
        logic [9:0] act_end;
        logic [9:0] ram_ptr;
        logic ram_wr;
        logic [9:0] ram_addr;
        logic [31:0] ram_data;
        logic [5:0] gen_state;
        logic [31:0] ftw;
        logic [15:0] pow;
        logic [13:0] asf;
        logic [7:0] osf;
        logic [5:0] comb_integrator_interp_filter;
        logic inv;
        logic byp;
    } usp_state_t;

    usp_state_t st_r;
    usp_state_t st_nxt;

    function automatic logic [9:0] seg_start_of(input logic [47:0] seg);
        seg_start_of = seg[USP_SEG_START_LSB +: 10];
    endfunction : seg_start_of

    function automatic logic [9:0] seg_end_of(input logic [47:0] seg);
        seg_end_of = seg[USP_SEG_END_LSB +: 10];
    endfunction : seg_end_of

    function automatic logic is_prof(input logic [4:0] a);
        is_prof = (a >= USP_ADDR_PROF0) && (a <= USP_ADDR_PROF7);
    endfunction : is_prof

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [2:0] widx;
        logic [2:0] ridx;
        logic [63:0] ap;
        logic tog_rise;
        logic tog_fall;
        ap = 64'h0000_0000_0000_0000;
        tog_rise = 1'b0;
        tog_fall = 1'b0;
        st_nxt = st_r;
        widx = 3'(reg_addr - USP_ADDR_PROF0);
        ridx = 3'(reg_addr - USP_ADDR_PROF0);
        st_nxt.ram_wr = 1'b0;
        st_nxt.rvalid = 1'b0;

        if (reg_wr) begin
            case (reg_addr)
                USP_ADDR_SYNC: st_nxt.sync = reg_wdata[31:0] & USP_SYNC_MASK;
                USP_ADDR_SEG0: st_nxt.seg0 = reg_wdata[47:0] & USP_SEG_MASK;
                USP_ADDR_SEG1: st_nxt.seg1 = reg_wdata[47:0] & USP_SEG_MASK;
                USP_ADDR_GPIO_CFG: st_nxt.gpio_cfg = reg_wdata[15:0];
                USP_ADDR_GPIO_DAT: st_nxt.gpio_dat = reg_wdata[15:0];
                USP_ADDR_RAM: begin
                    // Each word lands at the next address of the active segment
                    st_nxt.ram_word = reg_wdata[31:0];
                    st_nxt.ram_wr = 1'b1;
                    st_nxt.ram_addr = st_r.ram_ptr;
                    st_nxt.ram_data = reg_wdata[31:0];
                    st_nxt.ram_ptr = (st_r.ram_ptr == st_r.act_end) ? st_r.act_start
                                                                    : 10'(st_r.ram_ptr + 10'h001);
                end
                default: begin
                    if (is_prof(reg_addr)) begin
                        st_nxt.prof[widx] = reg_wdata;
                    end
                end
            endcase
        end

        if (reg_rd) begin
            st_nxt.rvalid = 1'b1;
            case (reg_addr)
                USP_ADDR_SYNC: st_nxt.rdata = {32'h0000_0000, st_r.sync};
                USP_ADDR_SEG0: st_nxt.rdata = {16'h0000, st_r.seg0};
                USP_ADDR_SEG1: st_nxt.rdata = {16'h0000, st_r.seg1};
                USP_ADDR_RAM: st_nxt.rdata = {32'h0000_0000, st_r.ram_word};
                USP_ADDR_GPIO_CFG: st_nxt.rdata = {48'h0000_0000_0000, st_r.gpio_cfg};
                USP_ADDR_GPIO_DAT: begin
                    // Output bits echo the latch, input bits show the pins
                    st_nxt.rdata = {48'h0000_0000_0000,
                        (st_r.gpio_cfg & st_r.gpio_dat) | (~st_r.gpio_cfg & gpio_in)};
                end
                default: begin
                    st_nxt.rdata = is_prof(reg_addr) ? st_r.prof[ridx]
                                                     : 64'h0000_0000_0000_0000;
                end
            endcase
        end

        // Segment select follows the toggle pin edges while RAM is enabled
        tog_rise = segment_toggle_pin & ~st_r.toggle_q;
        tog_fall = ~segment_toggle_pin & st_r.toggle_q;
        st_nxt.toggle_q = segment_toggle_pin;
        if (cfg_ram_enable && tog_rise) begin
            st_nxt.act_start = seg_start_of(st_r.seg0);
            st_nxt.act_end = seg_end_of(st_r.seg0);
            st_nxt.ram_ptr = seg_start_of(st_r.seg0);
        end else if (cfg_ram_enable && tog_fall) begin
            st_nxt.act_start = seg_start_of(st_r.seg1);
            st_nxt.act_end = seg_end_of(st_r.seg1);
            st_nxt.ram_ptr = seg_start_of(st_r.seg1);
        end

        // Internal clock generator; a received sync pulse presets it
        if (sync_in_pulse && st_r.sync[USP_SYNC_RX_EN_BIT]) begin
            st_nxt.gen_state = st_r.sync[USP_SYNC_PRESET_LSB +: 6];
        end else begin
            st_nxt.gen_state = 6'(st_r.gen_state + 6'h01);
        end

        // Active profile decode, registered so outputs stay glitch free
        ap = st_r.prof[profile_sel];
        st_nxt.ftw = ap[USP_PF_FTW_LSB +: 32];
        st_nxt.pow = ap[USP_PF_POW_LSB +: 16];
        st_nxt.asf = 14'h0000;
        st_nxt.osf = 8'h00;
        st_nxt.comb_integrator_interp_filter = 6'h00;
        st_nxt.inv = 1'b0;
        st_nxt.byp = 1'b0;
        case (usp_mode_t'(cfg_mode))
            USP_MODE_TONE: begin
                st_nxt.asf = ap[USP_PF_ASF_LSB +: 14];
            end
            USP_MODE_QUC: begin
                st_nxt.comb_integrator_interp_filter = ap[USP_PF_CCI_LSB +: 6];
                st_nxt.inv = ap[USP_PF_INV_BIT];
                st_nxt.byp = ap[USP_PF_BYP_BIT];
                st_nxt.osf = ap[USP_PF_OSF_LSB +: 8];
            end
            USP_MODE_INTERP: begin
                // Frequency and phase have no meaning without the carrier
                st_nxt.ftw = 32'h0000_0000;
                st_nxt.pow = 16'h0000;
                st_nxt.comb_integrator_interp_filter = ap[USP_PF_CCI_LSB +: 6];
                st_nxt.byp = ap[USP_PF_BYP_BIT];
                st_nxt.osf = ap[USP_PF_OSF_LSB +: 8];
            end
            default: begin
                st_nxt.comb_integrator_interp_filter = 6'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.sync <= USP_SYNC_RST;
            st_r.prof <= {USP_NPROF{USP_PROF_RST}};
            st_r.seg0 <= USP_SEG_RST;
            st_r.seg1 <= USP_SEG_RST;
            st_r.gpio_cfg <= USP_GPIO_RST;
            st_r.gpio_dat <= USP_GPIO_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign sync_valid_delay = st_r.sync[USP_SYNC_VAL_DLY_LSB +: 4];
    assign sync_rx_enable = st_r.sync[USP_SYNC_RX_EN_BIT];
    assign sync_gen_enable = st_r.sync[USP_SYNC_GEN_EN_BIT];
    assign sync_gen_falling = st_r.sync[USP_SYNC_GEN_POL_BIT];
    assign sync_gen_delay = st_r.sync[USP_SYNC_GEN_DLY_LSB +: 5];
    assign sync_rx_delay = st_r.sync[USP_SYNC_RX_DLY_LSB +: 5];
    assign clk_gen_state = st_r.gen_state;
    assign synth_ftw = st_r.ftw;
    assign synth_pow = st_r.pow;
    assign synth_asf = st_r.asf;
    assign out_scale = st_r.osf;
    assign cci_rate = st_r.comb_integrator_interp_filter;
    assign spectral_invert = st_r.inv;
    assign inv_cci_bypass = st_r.byp;
    assign seg_start = st_r.act_start;
    assign seg_end = st_r.act_end;
    assign ram_wr = st_r.ram_wr;
    assign ram_addr = st_r.ram_addr;
    assign ram_data = st_r.ram_data;
    assign gpio_out = st_r.gpio_dat;
    assign gpio_oe = st_r.gpio_cfg;

endmodule : usp_regs
